//--- design/dfcf_defines.vh
// Purpose: shared constants of the differential clock fanout control block
// Assumes: 10 MHz system clock
// Notes:   offsets, field positions, reset values and timing counts
`ifndef DFCF_DEFINES_VH
`define DFCF_DEFINES_VH

`define DFCF_NUM_PAIRS     18
`define DFCF_LOW_GRP_TOP   4
`define DFCF_IND_TOP       14
`define DFCF_REG_FREQ      8'h00
`define DFCF_FREQ_MSB      2
`define DFCF_FREQ_LATCH    2
`define DFCF_FREQ_RST      3'h5
`define DFCF_FREQ_LOW_BITS 2'h1
`define DFCF_FREQ_RSVD     3'h7
`define DFCF_ADDR_BASE     8'hD4
`define DFCF_MODE_LOBW     2'h0
`define DFCF_MODE_BYP      2'h1
`define DFCF_MODE_HIBW     2'h3
`define DFCF_CLK_NS        100
`define DFCF_PD_EN_US      300
`define DFCF_PD_EN_CYC     ((`DFCF_PD_EN_US * 1000) / `DFCF_CLK_NS)
// wake-up wait in clocks; leaves room for the pair latency inside the 300 us limit
`define DFCF_PD_SETTLE_CYC 12'h9C4
`define DFCF_OE_LAT_MIN    4
`define DFCF_OE_LAT_MAX    12

`endif

//--- design/dfcf_pair_gate.v
// Purpose: enable gating of one differential output pair
// Assumes: ref_lvl and want_en are already synchronised to clk
// Notes:   outside force_off, enable changes only while the reference is low, so no runt pulse
`timescale 1ns/1ps
`include "dfcf_defines.vh"

module dfcf_pair_gate #(
  parameter LAT = `DFCF_OE_LAT_MIN
) (
  input  wire clk,
  input  wire rst_b,
  input  wire ref_lvl,
  input  wire ref_tick,
  input  wire want_en,
  input  wire force_off,
  output reg  out_true_q,
  output reg  out_comp_q,
  output reg  out_oe_n_q
);

  reg       en_q;
  reg [3:0] cnt_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q  <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (force_off)
    begin
      // power-down cuts the pair at once, no boundary wait
      en_q  <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (want_en != en_q)
    begin
      if (cnt_q >= LAT[3:0] && !ref_lvl)
      begin
        en_q  <= want_en;
        cnt_q <= 4'h0;
      end
      else if (ref_tick && cnt_q < LAT[3:0])
        cnt_q <= cnt_q + 4'h1;
    end
    else
      cnt_q <= 4'h0;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_true_q <= 1'b0;
      out_comp_q <= 1'b0;
      out_oe_n_q <= 1'b1;
    end
    else
    begin
      // true and complement follow the reference
      out_true_q <= en_q & ref_lvl;
      out_comp_q <= en_q & ~ref_lvl;
      out_oe_n_q <= ~en_q;
    end
  end

endmodule

//--- design/dfcf_top.v
// Purpose: control logic of an 18-pair differential clock fanout buffer
// Assumes: pins arrive asynchronous; reference clocks slower than clk / 2
// Notes:   SMBus slave exposes byte 0 only; analog PLL lives outside
// Function
// - eighteen true/complement output pairs follow the selected reference
// - rate strap low gives 133 MHz, high gives 100 MHz
// - byte 0 bit 2 holds latched rate strap, bits 1:0 become 01
// - software writes byte 0 bits 2:0 for other rates; 111 is reserved
// - trilevel mode pin: low low-bandwidth, mid bypass, high high-bandwidth
// - power-good rising edge latches straps, then PLL runs unless in bypass mode, outputs enable
// - power-good low stops PLL and floats every output pair
// - reference select low routes second input, high the first
// - pairs 5 to 14 each have an active-low enable
// - one active-low enable drives pairs 15, 16 and 17
// - one active-low enable drives pairs 0 through 4
// - two address straps give target address D4, D6, D8, DA
// - target address depends on the straps only, not on the mode
// - pair starts or stops 4 to 12 reference cycles after enable change
// - outputs enabled within 300 us after power-good rises
`timescale 1ns/1ps
`include "dfcf_defines.vh"

module dfcf_top #(
  parameter OE_LAT = `DFCF_OE_LAT_MIN
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ref_clock_first,
  input  wire        ref_clock_second,
  input  wire        ref_select,
  input  wire        rate_strap,
  input  wire [1:0]  pll_mode_trilevel,
  input  wire        power_good_powerdown_n,
  input  wire        target_addr_strap_hi,
  input  wire        target_addr_strap_lo,
  input  wire [9:0]  pair_enable_n,
  input  wire        upper_group_enable_n,
  input  wire        lower_group_enable_n,
  input  wire        smb_clk,
  input  wire        smb_dat_in,
  output wire        smb_dat_out,
  output wire        smb_dat_oe_n,
  output wire [17:0] clock_out_pair_true,
  output wire [17:0] clock_out_pair_comp,
  output wire [17:0] clock_out_pair_oe_n,
  output reg         pll_run_q,
  output reg         pll_bypass_q,
  output reg         pll_high_bw_q,
  output reg  [2:0]  freq_code_q
);

  localparam NS = 23;
  localparam S_IDLE  = 3'h0;
  localparam S_ADDR  = 3'h1;
  localparam S_ACK   = 3'h2;
  localparam S_RX    = 3'h3;
  localparam S_TX    = 3'h4;
  localparam S_TXACK = 3'h5;
  localparam [11:0] PD_CYC = `DFCF_PD_SETTLE_CYC;

  // two-stage synchroniser for every pin
  reg  [NS-1:0] sync1_q;
  reg  [NS-1:0] sync2_q;
  wire [NS-1:0] pins = {ref_clock_first, ref_clock_second, ref_select, rate_strap,
                        pll_mode_trilevel, power_good_powerdown_n, target_addr_strap_hi,
                        target_addr_strap_lo, pair_enable_n, upper_group_enable_n,
                        lower_group_enable_n, smb_clk, smb_dat_in};

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= {NS{1'b0}};
      sync2_q <= {NS{1'b0}};
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  wire       s_ref_a  = sync2_q[22];
  wire       s_ref_b  = sync2_q[21];
  wire       s_sel    = sync2_q[20];
  wire       s_rate   = sync2_q[19];
  wire [1:0] s_mode   = sync2_q[18:17];
  wire       s_pgd    = sync2_q[16];
  wire [1:0] s_astrap = sync2_q[15:14];
  wire [9:0] s_ind_n  = sync2_q[13:4];
  wire       s_up_n   = sync2_q[3];
  wire       s_lo_n   = sync2_q[2];
  wire       s_scl    = sync2_q[1];
  wire       s_sda    = sync2_q[0];

  wire ref_lvl = s_sel ? s_ref_a : s_ref_b;

  reg        ref_prev_q;
  reg        pgd_prev_q;
  reg [1:0]  mode_lat_q;
  reg [1:0]  astrap_q;
  reg [11:0] pd_cnt_q;
  wire       ref_tick = ref_lvl & ~ref_prev_q;
  wire       pgd_rise = s_pgd & ~pgd_prev_q;
  wire       live     = s_pgd && (pd_cnt_q == PD_CYC);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_prev_q <= 1'b0;
      pgd_prev_q <= 1'b0;
      mode_lat_q <= `DFCF_MODE_LOBW;
      astrap_q   <= 2'h0;
      pd_cnt_q   <= 12'h000;
    end
    else
    begin
      ref_prev_q <= ref_lvl;
      pgd_prev_q <= s_pgd;
      if (pgd_rise)
      begin
        mode_lat_q <= s_mode;
        astrap_q   <= s_astrap;
      end
      if (!s_pgd || pgd_rise)
        pd_cnt_q <= 12'h000;
      else if (pd_cnt_q != PD_CYC)
        pd_cnt_q <= pd_cnt_q + 12'h001;
    end
  end

  // mode decode; PLL stops while powered down
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pll_run_q     <= 1'b0;
      pll_bypass_q  <= 1'b0;
      pll_high_bw_q <= 1'b0;
    end
    else
    begin
      pll_bypass_q  <= (mode_lat_q == `DFCF_MODE_BYP);
      pll_high_bw_q <= (mode_lat_q == `DFCF_MODE_HIBW);
      pll_run_q     <= s_pgd && !pgd_rise && (mode_lat_q != `DFCF_MODE_BYP);
    end
  end

  wire [17:0] want_en = {18{live}} & ~{{3{s_up_n}}, s_ind_n, {5{s_lo_n}}};

  genvar gi;
  generate
    for (gi = 0; gi < `DFCF_NUM_PAIRS; gi = gi + 1)
    begin : g_pair
      dfcf_pair_gate #(
        .LAT (OE_LAT)
      ) u_gate (
        .clk        (clk),
        .rst_b      (rst_b),
        .ref_lvl    (ref_lvl),
        .ref_tick   (ref_tick),
        .want_en    (want_en[gi]),
        .force_off  (~s_pgd),
        .out_true_q (clock_out_pair_true[gi]),
        .out_comp_q (clock_out_pair_comp[gi]),
        .out_oe_n_q (clock_out_pair_oe_n[gi])
      );
    end
  endgenerate

  wire [7:0] target_addr = `DFCF_ADDR_BASE + {5'h00, astrap_q, 1'b0};

  // SMBus target
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg       rw_q;
  reg       first_q;
  reg       drv_q;
  reg       scl_prev_q;
  reg       sda_prev_q;
  wire      scl_rise = s_scl & ~scl_prev_q;
  wire      scl_fall = ~s_scl & scl_prev_q;
  wire      bus_start = s_scl & scl_prev_q & sda_prev_q & ~s_sda;
  wire      bus_stop  = s_scl & scl_prev_q & ~sda_prev_q & s_sda;
  wire      wr_hit = scl_fall && st_q == S_RX && bit_q == 4'h8 && !first_q
                     && ptr_q == `DFCF_REG_FREQ;

  function [7:0] rd_val;
    input [7:0] p;
    input [2:0] f;
    begin
      rd_val = (p == `DFCF_REG_FREQ) ? {5'h00, f} : 8'h00;
    end
  endfunction

  wire [7:0] rd_cur = rd_val(ptr_q, freq_code_q);
  wire [7:0] rd_nxt = rd_val(ptr_q + 8'h01, freq_code_q);

  assign smb_dat_out  = 1'b0;
  assign smb_dat_oe_n = ~drv_q;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q       <= S_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      ptr_q      <= 8'h00;
      rw_q       <= 1'b0;
      first_q    <= 1'b0;
      drv_q      <= 1'b0;
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
    end
    else
    begin
      scl_prev_q <= s_scl;
      sda_prev_q <= s_sda;
      if (bus_start)
      begin
        st_q    <= S_ADDR;
        bit_q   <= 4'h0;
        first_q <= 1'b1;
        drv_q   <= 1'b0;
      end
      else if (bus_stop)
      begin
        st_q  <= S_IDLE;
        drv_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_q)
          S_ADDR, S_RX:
          begin
            sh_q  <= {sh_q[6:0], s_sda};
            bit_q <= bit_q + 4'h1;
          end
          S_TX:    bit_q <= bit_q + 4'h1;
          // master nack ends the read
          S_TXACK: if (s_sda) st_q <= S_IDLE;
          default: bit_q <= bit_q;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_q)
          S_ADDR:
            if (bit_q == 4'h8)
            begin
              if (sh_q[7:1] == target_addr[7:1])
              begin
                rw_q  <= sh_q[0];
                drv_q <= 1'b1;
                st_q  <= S_ACK;
              end
              else
                st_q <= S_IDLE;
            end
          S_RX:
            if (bit_q == 4'h8)
            begin
              drv_q   <= 1'b1;
              st_q    <= S_ACK;
              first_q <= 1'b0;
              ptr_q   <= first_q ? sh_q : ptr_q + 8'h01;
            end
          S_ACK:
          begin
            bit_q <= 4'h0;
            if (rw_q)
            begin
              sh_q  <= rd_cur;
              drv_q <= ~rd_cur[7];
              st_q  <= S_TX;
            end
            else
            begin
              drv_q <= 1'b0;
              st_q  <= S_RX;
            end
          end
          S_TX:
            if (bit_q == 4'h8)
            begin
              drv_q <= 1'b0;
              st_q  <= S_TXACK;
            end
            else
            begin
              sh_q  <= {sh_q[6:0], 1'b0};
              drv_q <= ~sh_q[6];
            end
          S_TXACK:
          begin
            ptr_q <= ptr_q + 8'h01;
            bit_q <= 4'h0;
            sh_q  <= rd_nxt;
            drv_q <= ~rd_nxt[7];
            st_q  <= S_TX;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // byte 0 frequency code; a strap latch wins over a same-cycle write
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      freq_code_q <= `DFCF_FREQ_RST;
    else if (pgd_rise)
      // latch rate strap into bit 2
      freq_code_q <= {s_rate, `DFCF_FREQ_LOW_BITS};
    else if (wr_hit && sh_q[`DFCF_FREQ_MSB:0] != `DFCF_FREQ_RSVD)
      freq_code_q <= sh_q[`DFCF_FREQ_MSB:0];
  end

endmodule

//--- verification/dfcf_ref_gen.sv
// Purpose: upstream reference clock source
// Assumes: both rates far below clk / 4
// Notes:   free running; half periods are per-instance knobs
`timescale 1ns/1ps
module dfcf_ref_gen #(
  parameter HALF_A = 400,
  parameter HALF_B = 600
) (
  output logic ref_a,
  output logic ref_b
);
  // unequal rates, so a wrong input select shows as a wrong period
  initial ref_a = 1'b0;
  initial ref_b = 1'b0;
  always #(HALF_A) ref_a = ~ref_a;
  always #(HALF_B) ref_b = ~ref_b;
endmodule

//--- verification/dfcf_top_assertions.sv
// Purpose: port checks of the fanout control top
// Assumes: one clk domain, rst_b async low
// Notes:   bound into every dfcf_top
`timescale 1ns/1ps
module dfcf_checker (
  input wire        clk,
  input wire        rst_b,
  input wire        power_good_powerdown_n,
  input wire [9:0]  pair_enable_n,
  input wire [17:0] clock_out_pair_true,
  input wire [17:0] clock_out_pair_comp,
  input wire [17:0] clock_out_pair_oe_n,
  input wire        pll_run_q,
  input wire        pll_bypass_q,
  input wire        pll_high_bw_q,
  input wire [2:0]  freq_code_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sync flops delay the forced float by a few clocks
  sequence s_pd_held;
    !power_good_powerdown_n [*5];
  endsequence
  sequence s_p5_on;
    $fell(clock_out_pair_oe_n[5]);
  endsequence
  property p_pd_float;
    s_pd_held |-> &clock_out_pair_oe_n;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("pair driven");
  property p_pd_stop;
    s_pd_held |-> !pll_run_q;
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("pll runs");
  property p_diff;
    &((clock_out_pair_true ^ clock_out_pair_comp) | clock_out_pair_oe_n);
  endproperty
  a_diff: assert property (p_diff) else $error("pair not differential");
  property p_low_grp;
    clock_out_pair_oe_n[4:0] == {5{clock_out_pair_oe_n[0]}};
  endproperty
  a_low_grp: assert property (p_low_grp) else $error("lower group split");
  property p_up_grp;
    clock_out_pair_oe_n[17:15] == {3{clock_out_pair_oe_n[15]}};
  endproperty
  a_up_grp: assert property (p_up_grp) else $error("upper group split");
  property p_no_runt;
    s_p5_on |-> !clock_out_pair_true[5];
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("runt on start");
  property p_start_late;
    s_p5_on |-> $past(!pair_enable_n[0], 4);
  endproperty
  a_start_late: assert property (p_start_late) else $error("early start");
  property p_stop_late;
    $rose(clock_out_pair_oe_n[5]) |->
      $past(pair_enable_n[0], 4) || $past(!power_good_powerdown_n, 2);
  endproperty
  a_stop_late: assert property (p_stop_late) else $error("early stop");
  property p_mode;
    pll_bypass_q |-> !pll_run_q && !pll_high_bw_q;
  endproperty
  a_mode: assert property (p_mode) else $error("mode clash");
  property p_rsvd;
    freq_code_q != 3'h7;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code");
endmodule

bind dfcf_top dfcf_checker dfcf_checker_inst (.clk, .rst_b, .power_good_powerdown_n,
  .pair_enable_n, .clock_out_pair_true, .clock_out_pair_comp, .clock_out_pair_oe_n,
  .pll_run_q, .pll_bypass_q, .pll_high_bw_q, .freq_code_q);

//--- verification/diff_clock_fanout_control_tb.sv
// Purpose: directed regression of the fanout control block
// Assumes: 10 MHz clk, references from dfcf_ref_gen
// Notes:   SMBus bit-banged with 5-clock phases
`timescale 1ns/1ps
`include "dfcf_defines.vh"
module diff_clock_fanout_control_tb;
  logic        clk, rst_b, ref_select, rate_strap, power_good_powerdown_n;
  logic        target_addr_strap_hi, target_addr_strap_lo, smb_clk, sda_h;
  logic        upper_group_enable_n, lower_group_enable_n, ak, nk;
  logic [1:0]  pll_mode_trilevel;
  logic [9:0]  pair_enable_n;
  logic [7:0]  rd;
  wire         ref_clock_first, ref_clock_second, smb_dat_out, smb_dat_oe_n;
  wire         pll_run_q, pll_bypass_q, pll_high_bw_q;
  wire  [2:0]  freq_code_q;
  wire  [17:0] clock_out_pair_true, clock_out_pair_comp, clock_out_pair_oe_n;
  // open-drain data line with pull-up
  wire         smb_dat_in = sda_h & (smb_dat_oe_n | smb_dat_out);
  integer      mismatches = 0, num_checks = 0, i, n;
  logic [1:0]  modes [3] = '{2'h0, 2'h3, 2'h1};
  logic [2:0]  m_exp [3] = '{3'h4, 3'h5, 3'h2};

  dfcf_ref_gen dfcf_ref_gen_inst (.ref_a(ref_clock_first), .ref_b(ref_clock_second));
  dfcf_top dfcf_top_inst (.clk, .rst_b, .ref_clock_first, .ref_clock_second,
    .ref_select, .rate_strap, .pll_mode_trilevel, .power_good_powerdown_n,
    .target_addr_strap_hi, .target_addr_strap_lo, .pair_enable_n,
    .upper_group_enable_n, .lower_group_enable_n, .smb_clk, .smb_dat_in,
    .smb_dat_out, .smb_dat_oe_n, .clock_out_pair_true, .clock_out_pair_comp,
    .clock_out_pair_oe_n, .pll_run_q, .pll_bypass_q, .pll_high_bw_q, .freq_code_q);

  always #50 clk = ~clk;

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input string s, input logic [17:0] e, input logic [17:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        mismatches++;
        $display("wrong value %s expected %h seen %h", s, e, g);
      end
    end
  endtask

  task tick(input integer k);
    repeat (k) @(posedge clk);
  endtask

  task sbit(input logic b, output logic r);
    begin
      sda_h <= b;
      tick(5);
      smb_clk <= 1'b1;
      tick(5);
      r = smb_dat_in;
      smb_clk <= 1'b0;
      tick(5);
    end
  endtask

  task sbyte(input logic [7:0] v, output logic a);
    begin
      for (i = 7; i >= 0; i--) sbit(v[i], rd[i]);
      sbit(1'b1, a);
    end
  endtask

  task sstart;
    begin
      sda_h <= 1'b1;
      smb_clk <= 1'b1;
      tick(5);
      sda_h <= 1'b0;
      tick(5);
      smb_clk <= 1'b0;
      tick(5);
    end
  endtask

  task sstop;
    begin
      sda_h <= 1'b0;
      tick(5);
      smb_clk <= 1'b1;
      tick(5);
      sda_h <= 1'b1;
      tick(5);
    end
  endtask

  // address, pointer 0, one data byte
  task swr(input logic [7:0] a, input logic [7:0] d);
    begin
      sstart;
      sbyte(a, ak);
      sbyte(8'h00, nk);
      sbyte(d, nk);
      sstop;
    end
  endtask

  task count_rises(output integer c);
    logic p;
    begin
      c = 0;
      p = clock_out_pair_true[0];
      repeat (240)
      begin
        @(posedge clk);
        if (clock_out_pair_true[0] && !p) c++;
        p = clock_out_pair_true[0];
      end
    end
  endtask

  initial begin
    clk = 1'b0;
    rst_b <= 1'b0;
    ref_select <= 1'b1;
    rate_strap <= 1'b0;
    pll_mode_trilevel <= 2'h3;
    power_good_powerdown_n <= 1'b0;
    target_addr_strap_hi <= 1'b1;
    target_addr_strap_lo <= 1'b0;
    pair_enable_n <= 10'h2AA;
    upper_group_enable_n <= 1'b1;
    lower_group_enable_n <= 1'b0;
    smb_clk <= 1'b1;
    sda_h <= 1'b1;
    tick(6);
    rst_b <= 1'b1;
    tick(2);
    chk("oe_n", 18'h3FFFF, clock_out_pair_oe_n);
    power_good_powerdown_n <= 1'b1;
    tick(8);
    chk("freq", 18'h1, freq_code_q);
    chk("mode", 18'h5, {pll_run_q, pll_bypass_q, pll_high_bw_q});
    n = 0;
    // eight clocks have already passed since power-good rose
    while (clock_out_pair_oe_n[0] !== 1'b0 && n < `DFCF_PD_EN_CYC - 8)
    begin
      tick(1);
      n++;
    end
    if (clock_out_pair_oe_n[0] !== 1'b0)
    begin
      mismatches++;
      stop_test;
    end
    tick(2);
    chk("oe_n", {3'h7, 10'h2AA, 5'h00}, clock_out_pair_oe_n);
    count_rises(n);
    chk("rises a", 18'h1, 18'((n >= 29) && (n <= 31)));
    ref_select <= 1'b0;
    tick(4);
    count_rises(n);
    chk("rises b", 18'h1, 18'((n >= 19) && (n <= 21)));
    pair_enable_n <= 10'h2AB;
    upper_group_enable_n <= 1'b0;
    lower_group_enable_n <= 1'b1;
    tick(36);
    chk("p5 held", 18'h0, clock_out_pair_oe_n[5]);
    tick(108);
    chk("p5 off", 18'h1, clock_out_pair_oe_n[5]);
    chk("groups", {3'h0, 10'h2AB, 5'h1F}, clock_out_pair_oe_n);
    chk("low grp", 18'h1F, clock_out_pair_oe_n[4:0]);
    swr(8'hD8, 8'h06);
    chk("ack", 18'h0, ak);
    chk("freq", 18'h6, freq_code_q);
    swr(8'hD4, 8'h03);
    chk("freq", 18'h6, freq_code_q);
    swr(8'hD8, 8'h07);
    chk("freq", 18'h6, freq_code_q);
    // a read starts at the last pointer, so set it to 0 first
    sstart;
    sbyte(8'hD8, ak);
    sbyte(8'h00, nk);
    sstart;
    sbyte(8'hD9, ak);
    chk("ack rd", 18'h0, ak);
    sbyte(8'hFF, nk);
    sstop;
    chk("byte0", 18'h06, rd);
    rate_strap <= 1'b1;
    target_addr_strap_hi <= 1'b0;
    target_addr_strap_lo <= 1'b1;
    for (n = 0; n < 3; n++)
    begin
      power_good_powerdown_n <= 1'b0;
      tick(8);
      chk("float", 18'h3FFFF, clock_out_pair_oe_n);
      chk("stop", 18'h0, pll_run_q);
      pll_mode_trilevel <= modes[n];
      power_good_powerdown_n <= 1'b1;
      tick(8);
      chk("mode", m_exp[n], {pll_run_q, pll_bypass_q, pll_high_bw_q});
      chk("freq", 18'h5, freq_code_q);
    end
    swr(8'hD6, 8'h02);
    chk("ack", 18'h0, ak);
    chk("freq", 18'h2, freq_code_q);
    stop_test;
  end
endmodule
